// ===== design/port_direction_and_latch.sv
`timescale 1ns/1ps
module port_direction_and_latch (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [gpio_pkg::AW-1:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_bit,
    input wire logic [1:0] cpu_bit_op,
    input wire logic [gpio_pkg::SEL_W-1:0] cpu_bit_sel,
    input wire logic [gpio_pkg::PW-1:0] cpu_wdata,
    input wire logic cpu_rd,
    input wire logic [gpio_pkg::NPORT-1:0][gpio_pkg::PW-1:0] pin_in,
    output logic [gpio_pkg::NPORT-1:0][gpio_pkg::PW-1:0] pin_out,
    output logic [gpio_pkg::NPORT-1:0][gpio_pkg::PW-1:0] pin_oe_b,
    output logic [gpio_pkg::PW-1:0] cpu_rdata,
    output logic cpu_rvalid,
    output logic [gpio_pkg::PW-1:0] external_irq_req_set
);

    localparam int NP = gpio_pkg::NPORT;
    localparam int W = gpio_pkg::PW;
    localparam int IDX_W = $clog2(NP);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    typedef struct packed {
        logic hit_dir;
        logic hit_port;
        logic [IDX_W-1:0] idx;
    } dec_s;

    function automatic dec_s decode(input logic [gpio_pkg::AW-1:0] addr);
        dec_s d;
        d = '0;
        for (int i = 0; i < NP; i++) begin
            if (gpio_pkg::HAS_DIR[i] && addr == gpio_pkg::DIR_ADDR[i]) begin
                d.hit_dir = 1'b1;
                d.idx = IDX_W'(i);
            end
            if (addr == gpio_pkg::PORT_ADDR[i]) begin
                d.hit_port = 1'b1;
                d.idx = IDX_W'(i);
            end
        end
        return d;
    endfunction : decode

    dec_s dec;
    assign dec = decode(cpu_addr);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and port cells

    logic [NP-1:0][W-1:0] pin_level;
    logic [NP-1:0][W-1:0] dir_q;
    logic [NP-1:0][W-1:0] lat_q;
    logic [NP-1:0][W-1:0] rd_level;
    logic [NP-1:0] dir_we;
    logic [NP-1:0] lat_we;
    logic [NP-1:0][W-1:0] cell_wdata;

    pin_sync #(
        .WIDTH(NP * W)
    ) u_pin_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(pin_in),
        .sync_out(pin_level)
    );

    for (genvar g = 0; g < NP; g++) begin : g_port
        port_cell #(
            .DIR_ONE(gpio_pkg::DIR_ONE[g]),
            .DIR_ZERO(gpio_pkg::DIR_ZERO[g]),
            .OPEN_DRAIN(gpio_pkg::OPEN_DRAIN[g]),
            .HAS_LATCH(gpio_pkg::HAS_LATCH[g])
        ) u_cell (
            .clk(clk),
            .rst_b(rst_b),
            .dir_we(dir_we[g]),
            .lat_we(lat_we[g]),
            .wdata(cell_wdata[g]),
            .pin_level(pin_level[g]),
            .dir_q(dir_q[g]),
            .lat_q(lat_q[g]),
            .rd_level(rd_level[g]),
            .pin_out(pin_out[g]),
            .pin_oe_b(pin_oe_b[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write path: byte transfers and read-modify-write bit operations

    // A byte write and a bit operation in the same cycle: the byte write wins
    logic do_write;
    logic do_bit;
    assign do_write = cpu_wr;
    assign do_bit = cpu_bit && !cpu_wr;

    always_comb begin
        for (int i = 0; i < NP; i++) begin
            dir_we[i] = 1'b0;
            lat_we[i] = 1'b0;
            cell_wdata[i] = cpu_wdata;
            if (dec.idx == IDX_W'(i)) begin
                if (dec.hit_dir) begin
                    dir_we[i] = do_write || do_bit;
                    if (do_bit) begin
                        cell_wdata[i] = gpio_pkg::bit_apply(cpu_bit_op, dir_q[i], cpu_bit_sel);
                    end
                end
                if (dec.hit_port) begin
                    lat_we[i] = (do_write || do_bit) && gpio_pkg::HAS_LATCH[i];
                    // Whole port is the operand: input-mode bits take the pin level
                    if (do_bit) begin
                        cell_wdata[i] = gpio_pkg::bit_apply(cpu_bit_op, rd_level[i], cpu_bit_sel);
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path and port 0 interrupt request

    typedef struct packed {
        logic [W-1:0] rdata;
        logic rvalid;
        logic [W-1:0] p0_drive;
        logic [W-1:0] p0_out;
        logic [W-1:0] irq;
    } top_s;

    top_s state_ff;
    top_s nxt_state;
    logic [W-1:0] p0_out_now;
    logic [W-1:0] p0_drive_now;

    // Level that port 0 presents while a bit is in output mode
    assign p0_out_now = ~dir_q[gpio_pkg::P0];
    assign p0_drive_now = lat_q[gpio_pkg::P0] & p0_out_now;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.rvalid = cpu_rd;
        if (cpu_rd) begin
            nxt_state.rdata = gpio_pkg::UNMAPPED_DATA;
            if (dec.hit_dir) begin
                nxt_state.rdata = dir_q[dec.idx];
            end else if (dec.hit_port) begin
                nxt_state.rdata = rd_level[dec.idx];
            end
        end
        nxt_state.p0_drive = p0_drive_now;
        nxt_state.p0_out = p0_out_now;
        // Only bits that stayed in output mode count; a mode switch is not a level change
        nxt_state.irq = (p0_drive_now ^ state_ff.p0_drive) & p0_out_now & state_ff.p0_out;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff.rdata <= gpio_pkg::UNMAPPED_DATA;
            state_ff.rvalid <= 1'b0;
            state_ff.p0_drive <= gpio_pkg::ALL_ZERO;
            state_ff.p0_out <= gpio_pkg::ALL_ZERO;
            state_ff.irq <= gpio_pkg::ALL_ZERO;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign cpu_rdata = state_ff.rdata;
    assign cpu_rvalid = state_ff.rvalid;
    assign external_irq_req_set = state_ff.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_read_port;
        cpu_rd && dec.hit_port;
    endsequence

    sequence s_read_dir;
        cpu_rd && dec.hit_dir;
    endsequence

    sequence s_p0_out_change;
        ((p0_drive_now ^ state_ff.p0_drive) & p0_out_now & state_ff.p0_out) != gpio_pkg::ALL_ZERO;
    endsequence

    sequence s_p0_quiet;
        ((p0_drive_now ^ state_ff.p0_drive) & p0_out_now & state_ff.p0_out) == gpio_pkg::ALL_ZERO;
    endsequence

    a_read_port_data: assert property (s_read_port |=> cpu_rvalid && cpu_rdata == $past(rd_level[dec.idx]))
        else $error("port read returned wrong value");

    a_read_dir_data: assert property (s_read_dir |=> cpu_rvalid && cpu_rdata == $past(dir_q[dec.idx]))
        else $error("direction read returned wrong value");

    a_read_keeps_latch: assert property (cpu_rd && !cpu_wr && !cpu_bit |=> $stable(lat_q))
        else $error("read disturbed a latch");

    a_p0_irq_set: assert property (s_p0_out_change |=> external_irq_req_set != gpio_pkg::ALL_ZERO)
        else $error("port 0 output change raised no request");

    a_bit_op_latch: assert property (do_bit && dec.hit_port && gpio_pkg::HAS_LATCH[dec.idx]
        |=> lat_q[$past(dec.idx)] == gpio_pkg::bit_apply($past(cpu_bit_op), $past(rd_level[dec.idx]),
                                                          $past(cpu_bit_sel)))
        else $error("bit operation result not in latch");

    a_input_port_fixed: assert property (dir_q[gpio_pkg::P1] == gpio_pkg::ALL_ONE
        && pin_oe_b[gpio_pkg::P1] == gpio_pkg::ALL_ONE)
        else $error("input-only port became drivable");

    // Back-to-back writes are legal, so both views are checked in the first cycle only
    a_byte_write_latch: assert property (do_write && dec.hit_port && gpio_pkg::HAS_LATCH[dec.idx]
        |=> lat_q[$past(dec.idx)] == $past(cpu_wdata) && pin_out[$past(dec.idx)] == $past(cpu_wdata))
        else $error("byte write not held on latch and pins");

    a_bit_op_dir: assert property (do_bit && dec.hit_dir
        |=> dir_q[$past(dec.idx)] == ((gpio_pkg::bit_apply($past(cpu_bit_op), $past(dir_q[dec.idx]),
            $past(cpu_bit_sel)) | gpio_pkg::DIR_ONE[$past(dec.idx)]) & ~gpio_pkg::DIR_ZERO[$past(dec.idx)]))
        else $error("bit operation result not in direction register");

    a_irq_quiet: assert property (s_p0_quiet |=> external_irq_req_set == gpio_pkg::ALL_ZERO)
        else $error("port 0 request without an output change");

    // The request is built from last cycle's direction, hence the one-cycle look back
    a_irq_output_only: assert property ((external_irq_req_set & $past(dir_q[gpio_pkg::P0])) == gpio_pkg::ALL_ZERO)
        else $error("port 0 request on an input-mode bit");

    a_rvalid_only_read: assert property (!cpu_rd |=> !cpu_rvalid)
        else $error("read valid without a read");

    a_rdata_holds: assert property (!cpu_rd |=> $stable(cpu_rdata))
        else $error("read data changed without a read");

    a_port13_fixed: assert property (dir_q[gpio_pkg::P13] == gpio_pkg::ALL_ZERO
        && pin_oe_b[gpio_pkg::P13] == lat_q[gpio_pkg::P13])
        else $error("output-only port lost its drive");

    a_port1_no_latch: assert property (lat_q[gpio_pkg::P1] == gpio_pkg::ALL_ZERO)
        else $error("input-only port took a latch value");

    for (genvar g = 0; g < NP; g++) begin : g_port_chk
        // Each bit of a read follows its own direction, so mixed ports read back mixed
        a_read_out_bits: assert property ((rd_level[g] & ~dir_q[g]) == (lat_q[g] & ~dir_q[g]))
            else $error("output-mode bit does not read the latch");

        a_read_in_bits: assert property ((rd_level[g] & dir_q[g]) == (pin_level[g] & dir_q[g]))
            else $error("input-mode bit does not read the pin");

        a_pin_follows_latch: assert property (pin_out[g] == lat_q[g])
            else $error("pin output differs from latch");
    end

endmodule : port_direction_and_latch

// ===== include/gpio_pkg.sv
package gpio_pkg;

    localparam int PW = 8;
    localparam int NPORT = 11;
    localparam int AW = 16;
    localparam int SEL_W = 3;

    // Port slots: 0..7 are ports 0..7, 8 is port 10, 9 is port 12, 10 is port 13
    localparam int P0 = 0;
    localparam int P1 = 1;
    localparam int P13 = 10;

    localparam logic [PW-1:0] ALL_ZERO = 8'h00;
    localparam logic [PW-1:0] ALL_ONE = 8'hFF;
    localparam logic [PW-1:0] DIR_RESET = 8'hFF;
    localparam logic [PW-1:0] LATCH_RESET = 8'h00;
    localparam logic [PW-1:0] UNMAPPED_DATA = 8'h00;

    localparam logic [AW-1:0] NO_ADDR = 16'h0000;

    localparam logic [AW-1:0] DIR_ADDR [NPORT] = '{
        16'hFF20, NO_ADDR, 16'hFF22, 16'hFF23, 16'hFF24, 16'hFF25,
        16'hFF26, 16'hFF27, 16'hFF2A, 16'hFF2C, NO_ADDR};

    localparam logic [AW-1:0] PORT_ADDR [NPORT] = '{
        16'hFF00, 16'hFF01, 16'hFF02, 16'hFF03, 16'hFF04, 16'hFF05,
        16'hFF06, 16'hFF07, 16'hFF0A, 16'hFF0C, 16'hFF0D};

    // Direction bits forced to one (no pin, or input-only port)
    localparam logic [PW-1:0] DIR_ONE [NPORT] = '{
        8'h01, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'hF8, 8'hE0, 8'h00};

    // Direction bits forced to zero (output-only port)
    localparam logic [PW-1:0] DIR_ZERO [NPORT] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};

    localparam bit HAS_DIR [NPORT] = '{
        1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

    localparam bit HAS_LATCH [NPORT] = '{
        1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

    localparam bit OPEN_DRAIN [NPORT] = '{
        1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

    typedef enum logic [1:0] {
        OP_SET = 2'h0,
        OP_CLR = 2'h1,
        OP_NOT = 2'h2
    } bit_op_e;

    function automatic logic [PW-1:0] bit_apply(input logic [1:0] op, input logic [PW-1:0] val,
                                                 input logic [SEL_W-1:0] sel);
        logic [PW-1:0] one_hot;
        one_hot = ALL_ZERO;
        one_hot[sel] = 1'b1;
        case (op)
            OP_SET: bit_apply = val | one_hot;
            OP_CLR: bit_apply = val & ~one_hot;
            OP_NOT: bit_apply = val ^ one_hot;
            default: bit_apply = val;
        endcase
    endfunction : bit_apply

endpackage : gpio_pkg

// ===== design/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = gpio_pkg::PW
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_s;

    sync_s state_ff;
    sync_s nxt_state;

    if (WIDTH < 1) begin : g_chk
        $error("pin_sync: WIDTH must be at least 1");
    end

    // Only the second stage reads the first
    always_comb begin
        nxt_state.meta = async_in;
        nxt_state.stable = state_ff.meta;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sync_out = state_ff.stable;

endmodule : pin_sync

// ===== design/port_cell.sv
`timescale 1ns/1ps
module port_cell #(
    parameter logic [gpio_pkg::PW-1:0] DIR_ONE = gpio_pkg::ALL_ZERO,
    parameter logic [gpio_pkg::PW-1:0] DIR_ZERO = gpio_pkg::ALL_ZERO,
    parameter bit OPEN_DRAIN = 1'b0,
    parameter bit HAS_LATCH = 1'b1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic dir_we,
    input wire logic lat_we,
    input wire logic [gpio_pkg::PW-1:0] wdata,
    input wire logic [gpio_pkg::PW-1:0] pin_level,
    output logic [gpio_pkg::PW-1:0] dir_q,
    output logic [gpio_pkg::PW-1:0] lat_q,
    output logic [gpio_pkg::PW-1:0] rd_level,
    output logic [gpio_pkg::PW-1:0] pin_out,
    output logic [gpio_pkg::PW-1:0] pin_oe_b
);

    localparam logic [gpio_pkg::PW-1:0] DIR_INIT = (gpio_pkg::DIR_RESET | DIR_ONE) & ~DIR_ZERO;

    typedef struct packed {
        logic [gpio_pkg::PW-1:0] dir;
        logic [gpio_pkg::PW-1:0] lat;
    } cell_s;

    cell_s state_ff;
    cell_s nxt_state;

    if ((DIR_ONE & DIR_ZERO) != gpio_pkg::ALL_ZERO) begin : g_chk
        $error("port_cell: a direction bit cannot be forced both ways");
    end

    always_comb begin
        nxt_state = state_ff;
        if (dir_we) begin
            nxt_state.dir = (wdata | DIR_ONE) & ~DIR_ZERO;
        end
        // Latch written regardless of direction; buffer state decides the pin
        if (lat_we && HAS_LATCH) begin
            nxt_state.lat = wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff.dir <= DIR_INIT;
            state_ff.lat <= gpio_pkg::LATCH_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign dir_q = state_ff.dir;
    assign lat_q = state_ff.lat;
    // Output-mode bits read back the latch, input-mode bits the pin
    assign rd_level = (state_ff.dir & pin_level) | (~state_ff.dir & state_ff.lat);
    assign pin_out = state_ff.lat;

    if (OPEN_DRAIN) begin : g_od
        // N-channel only: pulls low on a zero, releases on a one
        assign pin_oe_b = state_ff.lat;
    end else begin : g_pp
        assign pin_oe_b = state_ff.dir;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_fixed_dir_bits: assert property (((dir_q & DIR_ONE) == DIR_ONE) && ((dir_q & DIR_ZERO) == '0))
        else $error("fixed direction bit changed");

    a_latch_holds: assert property (!lat_we |=> $stable(lat_q))
        else $error("latch changed without a write");

    a_dir_write: assert property (dir_we |=> dir_q == (($past(wdata) | DIR_ONE) & ~DIR_ZERO))
        else $error("direction write not stored");

    a_input_undriven: assert property (!OPEN_DRAIN |-> ((pin_oe_b & dir_q) == dir_q))
        else $error("input mode pin is driven");

endmodule : port_cell

// ===== dv/pin_model.sv
`timescale 1ns/1ps
module pin_model (
    input wire logic [gpio_pkg::NPORT-1:0][gpio_pkg::PW-1:0] pin_out,
    input wire logic [gpio_pkg::NPORT-1:0][gpio_pkg::PW-1:0] pin_oe_b,
    input wire logic [gpio_pkg::NPORT-1:0][gpio_pkg::PW-1:0] ext_level,
    output logic [gpio_pkg::NPORT-1:0][gpio_pkg::PW-1:0] pin_in
);
    // A released pin shows the outside level, never the last driven value
    always_comb begin
        for (int s = 0; s < gpio_pkg::NPORT; s++) begin
            pin_in[s] = (pin_out[s] & ~pin_oe_b[s]) | (ext_level[s] & pin_oe_b[s]);
        end
    end
endmodule : pin_model

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk;
    logic rst_b;
    logic [gpio_pkg::AW-1:0] cpu_addr;
    logic cpu_wr;
    logic cpu_bit;
    logic [1:0] cpu_bit_op;
    logic [gpio_pkg::SEL_W-1:0] cpu_bit_sel;
    logic [gpio_pkg::PW-1:0] cpu_wdata;
    logic cpu_rd;
    logic [gpio_pkg::NPORT-1:0][gpio_pkg::PW-1:0] pin_in;
    logic [gpio_pkg::NPORT-1:0][gpio_pkg::PW-1:0] pin_out;
    logic [gpio_pkg::NPORT-1:0][gpio_pkg::PW-1:0] pin_oe_b;
    logic [gpio_pkg::NPORT-1:0][gpio_pkg::PW-1:0] ext_level;
    logic [gpio_pkg::PW-1:0] cpu_rdata;
    logic cpu_rvalid;
    logic [gpio_pkg::PW-1:0] external_irq_req_set;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;

    port_direction_and_latch uut (.clk(clk), .rst_b(rst_b), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_bit(cpu_bit), .cpu_bit_op(cpu_bit_op), .cpu_bit_sel(cpu_bit_sel), .cpu_wdata(cpu_wdata),
        .cpu_rd(cpu_rd), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b), .cpu_rdata(cpu_rdata),
        .cpu_rvalid(cpu_rvalid), .external_irq_req_set(external_irq_req_set));
    pin_model pins (.pin_out(pin_out), .pin_oe_b(pin_oe_b), .ext_level(ext_level), .pin_in(pin_in));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    // Budget is generous: the whole sequence needs about 120 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge clk);
        cpu_wr = 1'b0;
    endtask : wr

    task automatic bop(input logic [15:0] a, input logic [1:0] op, input logic [2:0] s);
        @(negedge clk);
        cpu_addr = a;
        cpu_bit_op = op;
        cpu_bit_sel = s;
        cpu_bit = 1'b1;
        @(negedge clk);
        cpu_bit = 1'b0;
    endtask : bop

    // Read data and its valid flag are looked at in the one cycle valid stands
    task automatic rd_chk(input string n, input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge clk);
        cpu_rd = 1'b0;
        chk({n, " valid"}, 8'h01, {7'h00, cpu_rvalid});
        chk(n, e, cpu_rdata);
    endtask : rd_chk

    task automatic end_test(input string n);
        $display("test %s done", n);
    endtask : end_test

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [1:0] ops [3];
        logic [7:0] exp_bits [3];
        rst_b = 1'b0;
        cpu_addr = 16'h0000;
        cpu_wr = 1'b0;
        cpu_bit = 1'b0;
        cpu_bit_op = 2'h0;
        cpu_bit_sel = 3'h0;
        cpu_wdata = 8'h00;
        cpu_rd = 1'b0;
        ext_level = '0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        for (int i = 0; i < gpio_pkg::NPORT; i++) begin
            if (gpio_pkg::HAS_DIR[i]) begin
                rd_chk("dir reset", gpio_pkg::DIR_ADDR[i], 8'hFF);
                chk("oe reset", 8'hFF, pin_oe_b[i]);
                chk("latch reset", 8'h00, pin_out[i]);
            end
        end
        end_test("reset");
        for (int i = 0; i < gpio_pkg::NPORT; i++) begin
            if (gpio_pkg::HAS_DIR[i]) begin
                wr(gpio_pkg::DIR_ADDR[i], 8'h00);
                rd_chk("dir back", gpio_pkg::DIR_ADDR[i], gpio_pkg::DIR_ONE[i]);
                chk("oe per pin", gpio_pkg::DIR_ONE[i], pin_oe_b[i]);
            end
        end
        bop(gpio_pkg::DIR_ADDR[6], gpio_pkg::OP_SET, 3'h3);
        rd_chk("dir bit", gpio_pkg::DIR_ADDR[6], 8'h08);
        chk("oe bit", 8'h08, pin_oe_b[6]);
        end_test("direction");
        ext_level[2] = 8'h5A;
        wr(gpio_pkg::PORT_ADDR[2], 8'hA5);
        chk("out latch", 8'hA5, pin_out[2]);
        rd_chk("out read", gpio_pkg::PORT_ADDR[2], 8'hA5);
        rd_chk("out reread", gpio_pkg::PORT_ADDR[2], 8'hA5);
        ops = '{gpio_pkg::OP_SET, gpio_pkg::OP_CLR, gpio_pkg::OP_NOT};
        exp_bits = '{8'hE5, 8'hE4, 8'hE6};
        for (int k = 0; k < 3; k++) begin
            bop(gpio_pkg::PORT_ADDR[2], ops[k], (k == 0) ? 3'h6 : 3'(k - 1));
            chk("bit op", exp_bits[k], pin_out[2]);
        end
        end_test("output");
        wr(gpio_pkg::DIR_ADDR[3], 8'hFF);
        ext_level[3] = 8'h3C;
        wr(gpio_pkg::PORT_ADDR[3], 8'hC3);
        chk("in latch", 8'hC3, pin_out[3]);
        chk("in released", 8'hFF, pin_oe_b[3]);
        repeat (3) @(negedge clk);
        rd_chk("in read", gpio_pkg::PORT_ADDR[3], 8'h3C);
        wr(gpio_pkg::DIR_ADDR[3], 8'h00);
        rd_chk("latch kept", gpio_pkg::PORT_ADDR[3], 8'hC3);
        end_test("input");
        wr(gpio_pkg::DIR_ADDR[5], 8'hF0);
        ext_level[5] = 8'hA5;
        wr(gpio_pkg::PORT_ADDR[5], 8'h03);
        repeat (3) @(negedge clk);
        bop(gpio_pkg::PORT_ADDR[5], gpio_pkg::OP_SET, 3'h2);
        chk("mixed out bits", 8'h07, pin_out[5] & 8'h0F);
        chk("mixed in bits", 8'hA0, pin_out[5] & 8'hF0);
        chk("mixed oe", 8'hF0, pin_oe_b[5]);
        end_test("mixed");
        wr(gpio_pkg::PORT_ADDR[0], 8'h06);
        @(negedge clk);
        chk("irq pulse", 8'h06, external_irq_req_set);
        @(negedge clk);
        chk("irq one cycle", 8'h00, external_irq_req_set);
        wr(gpio_pkg::DIR_ADDR[0], 8'hFF);
        wr(gpio_pkg::PORT_ADDR[0], 8'h00);
        @(negedge clk);
        chk("irq input mode", 8'h00, external_irq_req_set);
        wr(gpio_pkg::PORT_ADDR[0], 8'h08);
        wr(gpio_pkg::DIR_ADDR[0], 8'hF7);
        @(negedge clk);
        chk("irq mode switch", 8'h00, external_irq_req_set);
        wr(gpio_pkg::PORT_ADDR[0], 8'h00);
        @(negedge clk);
        chk("irq after switch", 8'h08, external_irq_req_set);
        end_test("irq");
        wr(gpio_pkg::PORT_ADDR[1], 8'h00);
        chk("p1 released", 8'hFF, pin_oe_b[1]);
        chk("p1 no latch", 8'h00, pin_out[1]);
        wr(gpio_pkg::PORT_ADDR[10], 8'h5A);
        chk("p13 drive", 8'h5A, pin_oe_b[10]);
        chk("p13 latch", 8'h5A, pin_out[10]);
        rd_chk("p13 read", gpio_pkg::PORT_ADDR[10], 8'h5A);
        rd_chk("unmapped", 16'hFF10, 8'h00);
        end_test("fixed ports");
        stop_test();
    end
endmodule : tb
